// ---- hdl/cws_pkg.sv ----
/*
 * cws_pkg: opcodes, field positions, exception codes and widths for the
 * coprocessor and left-part word store unit.
 * Assumes a 64-bit core with 8-byte wide data path to the store port.
 */
package cws_pkg;
    localparam int          XLEN         = 64;
    localparam int          OP_HI        = 31;
    localparam int          OP_LO        = 26;
    localparam int          BASE_HI      = 25;
    localparam int          BASE_LO      = 21;
    localparam int          SRC_HI       = 20;
    localparam int          SRC_LO       = 16;
    localparam int          DISP_HI      = 15;
    localparam int          DISP_LO      = 0;
    localparam logic [5:0]  OP_FP_WORD   = 6'h39;
    localparam logic [5:0]  OP_COP2_WORD = 6'h3A;
    localparam logic [5:0]  OP_LEFT_WORD = 6'h2A;

    typedef enum logic [3:0] {
        CWS_EXC_NONE    = 4'h0,
        CWS_EXC_CPU     = 4'h1,
        CWS_EXC_RESV    = 4'h2,
        CWS_EXC_REFILL  = 4'h3,
        CWS_EXC_INVALID = 4'h4,
        CWS_EXC_MOD     = 4'h5,
        CWS_EXC_ADDR    = 4'h6,
        CWS_EXC_WATCH   = 4'h7,
        CWS_EXC_BUS     = 4'h8
    } cws_exc_t;

    typedef enum logic [1:0] {
        CWS_K_FP   = 2'h0,
        CWS_K_COP2 = 2'h1,
        CWS_K_LEFT = 2'h2,
        CWS_K_NONE = 2'h3
    } cws_kind_t;
endpackage : cws_pkg

// ---- hdl/cws_lane.sv ----
/*
 * cws_lane: pure byte-lane and data placement for one word store.
 * Assumes inputs are stable in the cycle they are presented.
 */
`timescale 1ns/1ns
module cws_lane
    import cws_pkg::*;
(
    // request
    input  wire cws_kind_t   i_kind,
    input  wire logic [2:0]  i_va_lo,
    input  wire logic        i_core_msb_first,
    input  wire logic [31:0] i_word,
    // placement
    output logic [7:0]       o_lanes,
    output logic [63:0]      o_data
);
    logic [1:0] byte_sel;
    logic       hi_half;
    logic [3:0] wmask;
    logic [31:0] wdata;

    always_comb begin
        byte_sel = i_va_lo[1:0] ^ {2{i_core_msb_first}};
        hi_half  = i_va_lo[2] ^ i_core_msb_first;
        if (i_kind == CWS_K_LEFT) begin
            unique case (byte_sel)
                2'h0: begin wmask = 4'h1; wdata = {24'h000000, i_word[31:24]}; end
                2'h1: begin wmask = 4'h3; wdata = {16'h0000, i_word[31:16]}; end
                2'h2: begin wmask = 4'h7; wdata = {8'h00, i_word[31:8]}; end
                2'h3: begin wmask = 4'hF; wdata = i_word; end
            endcase
        end else begin
            wmask = 4'hF;
            wdata = i_word;
        end
        o_lanes = hi_half ? {wmask, 4'h0} : {4'h0, wmask};
        o_data  = hi_half ? {wdata, 32'h00000000} : {32'h00000000, wdata};
    end
endmodule : cws_lane

// ---- hdl/cws_store_unit.sv ----
/*
 * cws_store_unit: decodes and issues the floating-point, coprocessor-two
 * and left-part word stores toward translation and the store port.
 * Assumes register files answer combinationally and the translation side
 * returns one result (with fault code) per issued request.
 */
`timescale 1ns/1ns
module cws_store_unit
    import cws_pkg::*;
#(
    parameter int PA_W = 36
) (
    // clock and reset
    input  wire logic            i_sys_clk,
    input  wire logic            i_srst,
    // instruction
    input  wire logic            i_ins_valid,
    input  wire logic [31:0]     i_ins_word,
    input  wire logic            i_cop1_usable,
    input  wire logic            i_cop2_usable,
    input  wire logic            i_cop2_present,
    input  wire logic            i_core_msb_first,
    input  wire logic            i_memory_msb_first,
    input  wire logic            i_user_byte_order_flip,
    // register files
    output logic [4:0]           o_base_idx,
    output logic [4:0]           o_src_idx,
    input  wire logic [63:0]     i_general_register_base,
    input  wire logic [63:0]     i_general_register_src,
    input  wire logic [63:0]     i_float_register,
    input  wire logic [63:0]     i_cop2_register,
    // translation
    output logic                 o_xlat_req,
    output logic [63:0]          o_target_byte_address,
    input  wire logic            i_xlat_done,
    input  wire logic [PA_W-1:0] i_xlat_paddr,
    input  wire logic [2:0]      i_cache_coherency_attr,
    input  wire cws_exc_t        i_xlat_exc,
    // store port
    output logic                 o_st_valid,
    output logic [PA_W-1:0]      o_st_paddr,
    output logic [7:0]           o_st_lanes,
    output logic [63:0]          o_st_data,
    output logic [2:0]           o_st_cca,
    input  wire logic            i_st_bus_err,
    // status
    output logic                 o_busy,
    output logic                 o_exc_valid,
    output cws_exc_t             o_exc_code,
    output logic [63:0]          o_exc_vaddr
);
    typedef enum logic [1:0] {
        CWS_S_IDLE = 2'h0,
        CWS_S_XLAT = 2'h1,
        CWS_S_DONE = 2'h2,
        CWS_S_RESP = 2'h3
    } cws_state_t;

    typedef struct packed {
        cws_state_t  st;
        cws_kind_t   kind;
        logic [31:0] word;
        logic [63:0] va;
        logic        xreq;
        logic        stv;
        logic [PA_W-1:0] pa;
        logic [7:0]  lanes;
        logic [63:0] data;
        logic [2:0]  cca;
        logic        excv;
        cws_exc_t    exc;
        logic        busy;
    } cws_reg_t;

    cws_reg_t   r;
    cws_reg_t   next_r;
    cws_kind_t  dec_kind;
    logic [63:0] ea;
    logic [31:0] src_word;
    logic [7:0]  lanes;
    logic [63:0] ldata;

    function automatic cws_kind_t decode(input logic [5:0] op);
        unique case (op)
            OP_FP_WORD:   decode = CWS_K_FP;
            OP_COP2_WORD: decode = CWS_K_COP2;
            OP_LEFT_WORD: decode = CWS_K_LEFT;
            default:      decode = CWS_K_NONE;
        endcase
    endfunction : decode

    assign dec_kind   = decode(i_ins_word[OP_HI:OP_LO]);
    assign o_base_idx = i_ins_word[BASE_HI:BASE_LO];
    assign o_src_idx  = i_ins_word[SRC_HI:SRC_LO];
    assign ea = i_general_register_base
              + {{(XLEN-16){i_ins_word[DISP_HI]}}, i_ins_word[DISP_HI:DISP_LO]};

    // low float word / low cop2 word / low gpr word
    always_comb begin
        unique case (dec_kind)
            CWS_K_FP:   src_word = i_float_register[31:0];
            CWS_K_COP2: src_word = i_cop2_register[31:0];
            default:    src_word = i_general_register_src[31:0];
        endcase
    end

    cws_lane u_lane (
        .i_kind           (r.kind),
        .i_va_lo          (r.va[2:0]),
        .i_core_msb_first (i_core_msb_first),
        .i_word           (r.word),
        .o_lanes          (lanes),
        .o_data           (ldata)
    );

    always_comb begin
        next_r      = r;
        next_r.stv  = 1'b0;
        next_r.excv = 1'b0;
        next_r.xreq = 1'b0;
        unique case (r.st)
            CWS_S_IDLE: begin
                if (i_ins_valid && dec_kind != CWS_K_NONE) begin
                    next_r.kind = dec_kind;
                    next_r.word = src_word;
                    next_r.va   = ea;
                    next_r.exc  = CWS_EXC_NONE;
                    if (dec_kind == CWS_K_FP && !i_cop1_usable) begin
                        next_r.excv = 1'b1;
                        next_r.exc  = CWS_EXC_CPU;
                    end else if (dec_kind == CWS_K_COP2 && !i_cop2_present) begin
                        next_r.excv = 1'b1;
                        next_r.exc  = CWS_EXC_RESV;
                    end else if (dec_kind == CWS_K_COP2 && !i_cop2_usable) begin
                        next_r.excv = 1'b1;
                        next_r.exc  = CWS_EXC_CPU;
                    // misaligned word / left not checked
                    end else if (dec_kind != CWS_K_LEFT && ea[1:0] != 2'h0) begin
                        next_r.excv = 1'b1;
                        next_r.exc  = CWS_EXC_ADDR;
                    end else begin
                        next_r.st   = CWS_S_XLAT;
                        next_r.xreq = 1'b1;
                    end
                end
            end
            CWS_S_XLAT: begin
                if (i_xlat_done) begin
                    if (i_xlat_exc != CWS_EXC_NONE) begin
                        next_r.excv = 1'b1;
                        next_r.exc  = i_xlat_exc;
                        next_r.st   = CWS_S_IDLE;
                    end else begin
                        next_r.pa = i_xlat_paddr;
                        // user order flip, left flips all three
                        if (r.kind == CWS_K_LEFT)
                            next_r.pa[2:0] = i_xlat_paddr[2:0] ^ {3{i_user_byte_order_flip}};
                        else
                            next_r.pa[2:0] = i_xlat_paddr[2:0] ^ {i_user_byte_order_flip, 2'h0};
                        if (r.kind == CWS_K_LEFT && !i_memory_msb_first)
                            next_r.pa[1:0] = 2'h0;
                        // address is high byte of word
                        next_r.lanes = lanes;
                        next_r.data  = ldata;
                        next_r.cca   = i_cache_coherency_attr;
                        next_r.stv   = 1'b1;
                        next_r.st    = CWS_S_DONE;
                    end
                end
            end
            CWS_S_DONE: begin
                // store port answers a cycle after the strobe
                next_r.st = CWS_S_RESP;
            end
            CWS_S_RESP: begin
                if (i_st_bus_err) begin
                    next_r.excv = 1'b1;
                    next_r.exc  = CWS_EXC_BUS;
                end
                next_r.st = CWS_S_IDLE;
            end
        endcase
        next_r.busy = next_r.st != CWS_S_IDLE;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_xlat_req            = r.xreq;
    assign o_target_byte_address = r.va;
    assign o_st_valid            = r.stv;
    assign o_st_paddr            = r.pa;
    assign o_st_lanes            = r.lanes;
    assign o_st_data             = r.data;
    assign o_st_cca              = r.cca;
    assign o_busy                = r.busy;
    assign o_exc_valid           = r.excv;
    assign o_exc_code            = r.exc;
    assign o_exc_vaddr           = r.va;

    misalign_no_store_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        o_st_valid |-> (r.kind == CWS_K_LEFT || r.va[1:0] == 2'h0))
        else $error("aligned store issued with misaligned address");
    misalign_exc_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (r.st == CWS_S_IDLE && i_ins_valid && dec_kind == CWS_K_FP && i_cop1_usable
         && ea[1:0] != 2'h0) |=> (o_exc_valid && o_exc_code == CWS_EXC_ADDR))
        else $error("address error missing");
    ea_form_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (r.st == CWS_S_IDLE && i_ins_valid && dec_kind != CWS_K_NONE)
        |=> o_target_byte_address == $past(ea))
        else $error("target address wrong");
    word_lanes_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (o_st_valid && r.kind != CWS_K_LEFT)
        |-> (o_st_lanes == 8'h0F || o_st_lanes == 8'hF0))
        else $error("word store lanes wrong");
    left_pa_clear_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (r.st == CWS_S_XLAT && i_xlat_done && i_xlat_exc == CWS_EXC_NONE
         && r.kind == CWS_K_LEFT && !i_memory_msb_first) |=> o_st_paddr[1:0] == 2'h0)
        else $error("little endian left address not cleared");
    left_full_word_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (o_st_valid && r.kind == CWS_K_LEFT && (r.va[1:0] ^ {2{i_core_msb_first}}) == 2'h3)
        |-> ($countones(o_st_lanes) == 4))
        else $error("left store lane count wrong");
    store_follows_xlat_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        o_xlat_req |-> ##[1:1000] (o_st_valid || o_exc_valid))
        else $error("no store or fault after translation");
    fp_data_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (r.st == CWS_S_IDLE && i_ins_valid && dec_kind == CWS_K_FP)
        |=> r.word == $past(i_float_register[31:0]))
        else $error("fp store data wrong");
    left_src_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (r.st == CWS_S_IDLE && i_ins_valid && dec_kind == CWS_K_LEFT)
        |=> (r.word == $past(i_general_register_src[31:0]) && !o_exc_valid))
        else $error("left store source or check wrong");

    fp_store_c: cover property (@(posedge i_sys_clk) o_st_valid && r.kind == CWS_K_FP);
    cop2_store_c: cover property (@(posedge i_sys_clk) o_st_valid && r.kind == CWS_K_COP2);
    left_store_c: cover property (@(posedge i_sys_clk) o_st_valid && r.kind == CWS_K_LEFT);
    addr_exc_c: cover property (@(posedge i_sys_clk) o_exc_valid && o_exc_code == CWS_EXC_ADDR);
endmodule : cws_store_unit

// ---- testbench/cws_xlat_model.sv ----
/*
 * cws_xlat_model: translation and store-path partner of the store unit.
 * Assumes one request in flight; the bench sets delay, fault and bus error.
 */
`timescale 1ns/1ns
module cws_xlat_model
    import cws_pkg::*;
#(
    parameter int PA_W = 36
) (
    // clock and reset
    input  wire logic            i_sys_clk,
    input  wire logic            i_srst,
    // from the store unit
    input  wire logic            i_xlat_req,
    input  wire logic [63:0]     i_addr,
    input  wire logic            i_st_valid,
    // bench controls
    input  wire logic [3:0]      i_delay,
    input  wire cws_exc_t        i_fault,
    input  wire logic            i_bus_fail,
    // answers
    output logic                 o_done,
    output logic [PA_W-1:0]      o_paddr,
    output logic [2:0]           o_cca,
    output cws_exc_t             o_exc,
    output logic                 o_bus_err
);
    // page frame inverted so a pass-through address is caught
    localparam logic [PA_W-1:0] FLIP = {{(PA_W-12){1'b1}}, 12'h000};
    logic [PA_W-1:0] held;
    logic [3:0]      cnt;
    logic            pend;
    always_ff @(posedge i_sys_clk) begin
        o_done    <= 1'b0;
        o_bus_err <= i_st_valid & i_bus_fail;
        // outside an answer or reset the lines toggle, never hold the last value
        o_paddr   <= ~o_paddr;
        o_cca     <= ~o_cca;
        o_exc     <= cws_exc_t'(~4'(o_exc));
        if (i_srst) begin
            pend    <= 1'b0;
            o_paddr <= '0;
            o_cca   <= 3'h0;
            o_exc   <= CWS_EXC_NONE;
        end else if (i_xlat_req) begin
            pend <= 1'b1;
            cnt  <= i_delay;
            held <= i_addr[PA_W-1:0] ^ FLIP;
        end else if (pend && cnt == 4'h0) begin
            pend    <= 1'b0;
            o_done  <= 1'b1;
            o_paddr <= held;
            o_cca   <= held[5:3];
            o_exc   <= i_fault;
        end else if (pend) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule : cws_xlat_model

// ---- testbench/tb.sv ----
/*
 * tb: self-checking bench for the word store unit.
 * Assumes register reads are combinational and one store at a time.
 */
`timescale 1ns/1ns
module tb
    import cws_pkg::*;
;
    localparam int PA_W = 36;
    localparam logic [PA_W-1:0] FLIP = {{(PA_W-12){1'b1}}, 12'h000};
    logic clk = 0, srst = 1, ins_valid = 0, core_r = 0, mem_r = 0, flip_r = 0;
    logic c1_r = 1, c2u_r = 1, c2p_r = 1, bus_r = 0, st_seen, ex_seen;
    logic [3:0]  dly_r = 4'h0;
    cws_exc_t    fault_r = CWS_EXC_NONE, ec;
    logic [31:0] ins = 32'h0;
    logic [63:0] base_r = 64'h0, src_r = 64'h0, fpr_r = 64'h0, cp2_r = 64'h0, va_e;
    logic done, bus_err, xreq, stv, busy, exv;
    logic [4:0]  bidx, sidx;
    logic [63:0] tadr, sdata, evaddr;
    logic [7:0]  lanes;
    logic [PA_W-1:0] paddr, spaddr;
    logic [2:0]  cca, scca;
    cws_exc_t    xexc, ecode;
    int bad_count = 0, n_tests = 0, n_req = 0;

    cws_store_unit #(.PA_W(PA_W)) DUT (.i_sys_clk(clk), .i_srst(srst),
        .i_ins_valid(ins_valid), .i_ins_word(ins), .i_cop1_usable(c1_r),
        .i_cop2_usable(c2u_r), .i_cop2_present(c2p_r), .i_core_msb_first(core_r),
        .i_memory_msb_first(mem_r), .i_user_byte_order_flip(flip_r),
        .o_base_idx(bidx), .o_src_idx(sidx), .i_general_register_base(base_r),
        .i_general_register_src(src_r), .i_float_register(fpr_r),
        .i_cop2_register(cp2_r), .o_xlat_req(xreq), .o_target_byte_address(tadr),
        .i_xlat_done(done), .i_xlat_paddr(paddr), .i_cache_coherency_attr(cca),
        .i_xlat_exc(xexc), .o_st_valid(stv), .o_st_paddr(spaddr), .o_st_lanes(lanes),
        .o_st_data(sdata), .o_st_cca(scca), .i_st_bus_err(bus_err), .o_busy(busy),
        .o_exc_valid(exv), .o_exc_code(ecode), .o_exc_vaddr(evaddr));
    cws_xlat_model #(.PA_W(PA_W)) xlat (.i_sys_clk(clk), .i_srst(srst),
        .i_xlat_req(xreq), .i_addr(tadr), .i_st_valid(stv), .i_delay(dly_r),
        .i_fault(fault_r), .i_bus_fail(bus_r), .o_done(done), .o_paddr(paddr),
        .o_cca(cca), .o_exc(xexc), .o_bus_err(bus_err));

    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (xreq === 1'b1) n_req++;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out

    // one instruction: base 3, source 7, then wait for store or fault
    task automatic run(input logic [5:0] op, input logic [63:0] b,
                       input logic [15:0] d);
        int i;
        logic idle;
        st_seen = 1'b0;
        ex_seen = 1'b0;
        va_e = b + {{48{d[15]}}, d};
        @(posedge clk);
        ins_valid <= 1'b1;
        ins <= {op, 5'h03, 5'h07, d};
        base_r <= b;
        @(posedge clk);
        ins_valid <= 1'b0;
        chk(64'(bidx), 64'h3);
        chk(64'(sidx), 64'h7);
        // first look falls in the cycle a pre-check fault stands
        for (i = 0; i < 40; i++) begin
            #1;
            if (stv === 1'b1) st_seen = 1'b1;
            if (exv === 1'b1) ex_seen = 1'b1;
            if (exv === 1'b1) ec = ecode;
            idle = (st_seen || ex_seen) && busy === 1'b0;
            @(posedge clk);
            if (idle) break;
        end
        if (i == 40) begin
            bad_count++;
            $display("unexpected at %0t: hang %h %h", $time, busy, 1'b0);
            close_out();
        end
    endtask : run

    task automatic exp_store(input logic [7:0] ln, input logic [63:0] dt,
                             input logic left);
        logic [PA_W-1:0] p;
        p = va_e[PA_W-1:0] ^ FLIP;
        p[2] = p[2] ^ flip_r;
        if (left) p[1:0] = p[1:0] ^ {2{flip_r}};
        if (left && !mem_r) p[1:0] = 2'h0;
        chk(64'({st_seen, ex_seen}), 64'h2);
        chk(64'(spaddr), 64'(p));
        chk(64'(lanes), 64'(ln));
        chk(sdata, dt);
        chk(64'(scca), 64'(va_e[5:3]));
    endtask : exp_store

    // aligned fp and cop-two stores, both byte orders and both halves
    task automatic t_aligned;
        logic [31:0] w;
        for (int k = 0; k < 2; k++) begin
            for (int c = 0; c < 4; c++) begin
                @(posedge clk);
                core_r <= c[0];
                flip_r <= c[1];
                dly_r <= c[1] ? 4'h9 : 4'h0;
                fpr_r <= 64'hDEAD_BEEF_0123_4567;
                cp2_r <= 64'hCAFE_F00D_89AB_CDEF;
                w = (k == 0) ? 32'h0123_4567 : 32'h89AB_CDEF;
                run(k ? OP_COP2_WORD : OP_FP_WORD, 64'h1_2345_6010 + 64'(4 * c[1]),
                    16'hFFF8);
                chk(64'(va_e[2]), 64'(c[1]));
                if (c[1] ^ c[0]) exp_store(8'hF0, {w, 32'h0}, 1'b0);
                else exp_store(8'h0F, {32'h0, w}, 1'b0);
            end
        end
        flip_r <= 1'b0;
        $display("aligned word stores done");
    endtask : t_aligned

    // misaligned coprocessor stores fault before translation
    task automatic t_misalign;
        int r;
        for (int k = 0; k < 2; k++) begin
            for (int a = 1; a < 4; a++) begin
                r = n_req;
                run(k ? OP_COP2_WORD : OP_FP_WORD, 64'h4000 + 64'(a), 16'h0020);
                chk(64'({st_seen, ex_seen, ec}), 64'({2'h1, CWS_EXC_ADDR}));
                chk(evaddr, va_e);
                chk(64'(n_req), 64'(r));
            end
        end
        $display("misaligned stores done");
    endtask : t_misalign

    // left-part store at every offset, core and memory order
    task automatic t_left;
        logic [1:0]  k;
        logic [7:0]  m;
        logic [31:0] d;
        for (int c = 0; c < 16; c++) begin
            @(posedge clk);
            core_r <= c[3];
            mem_r <= c[0];
            flip_r <= c[2];
            src_r <= 64'hFFFF_FFFF_A1B2_C3D4;
            run(OP_LEFT_WORD, 64'h8000 + 64'(c[2:0]), 16'h0010);
            k = c[1:0] ^ {2{c[3]}};
            m = (8'h1 << (3'(k) + 3'h1)) - 8'h1;
            d = 32'hA1B2_C3D4 >> (24 - 8 * k);
            if (c[2] ^ c[3]) exp_store(m << 4, {d, 32'h0}, 1'b1);
            else exp_store(m, {32'h0, d}, 1'b1);
        end
        flip_r <= 1'b0;
        $display("left part stores done");
    endtask : t_left

    // unusable, reserved, translation and bus faults
    task automatic t_faults;
        cws_exc_t codes [4] = '{CWS_EXC_REFILL, CWS_EXC_INVALID, CWS_EXC_MOD,
                                CWS_EXC_WATCH};
        @(posedge clk);
        c1_r <= 1'b0;
        run(OP_FP_WORD, 64'h100, 16'h0);
        chk(64'({st_seen, ex_seen, ec}), 64'({2'h1, CWS_EXC_CPU}));
        c1_r <= 1'b1;
        c2p_r <= 1'b0;
        run(OP_COP2_WORD, 64'h100, 16'h0);
        chk(64'({st_seen, ex_seen, ec}), 64'({2'h1, CWS_EXC_RESV}));
        c2p_r <= 1'b1;
        c2u_r <= 1'b0;
        run(OP_COP2_WORD, 64'h100, 16'h0);
        chk(64'({st_seen, ex_seen, ec}), 64'({2'h1, CWS_EXC_CPU}));
        c2u_r <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            fault_r <= codes[i[1:0]];
            dly_r <= 4'h5;
            run(i[2] ? OP_LEFT_WORD : OP_FP_WORD, 64'h200, 16'h0);
            chk(64'({st_seen, ex_seen, ec}), 64'({2'h1, codes[i[1:0]]}));
        end
        fault_r <= CWS_EXC_NONE;
        bus_r <= 1'b1;
        run(OP_LEFT_WORD, 64'h203, 16'h0);
        chk(64'({st_seen, ex_seen, ec}), 64'({2'h3, CWS_EXC_BUS}));
        bus_r <= 1'b0;
        $display("fault reporting done");
    endtask : t_faults

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_aligned();
        t_misalign();
        t_left();
        t_faults();
        close_out();
    end
endmodule : tb
